// ---- hw/word_capture_pkg.sv ----
/*
  Constants and carrier types shared by the telemetry word capture monitor.
  Assumes a 25 MHz system clock; all decoder signals are asynchronous pins.
*/
package word_capture_pkg;

  // ----------------------------------------------------------------
  // Frame format
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int SELECT_BITS = 7;
  localparam int MAX_WORD = 64;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int PRESET_US = 600;
  localparam int PRESET_CYCLES = (PRESET_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_BITS-1:0] CAPTURE_RESET = 16'h0000;
  localparam logic [3:0] DIGIT_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic serialData;
    logic bitClock;
    logic wordPulse;
    logic frameSync;
  } decoder_pins_t;

  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] units;
  } bcd_count_t;

endpackage

// ---- hw/capture_holding_reg.sv ----
/*
  Holding register for the captured word.
  Assumes the strobe is a one-cycle pulse on clk marking the capture edge.
*/
`timescale 1ns/1ps
`default_nettype none

module capture_holding_reg
  import word_capture_pkg::*;
#(
  parameter int WIDTH = WORD_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Capture strobe and data
  input wire logic strobe,
  input wire logic [WIDTH-1:0] wordIn,
  // Held word
  output logic [WIDTH-1:0] wordOut
);

  logic [WIDTH-1:0] word_r;
  logic [WIDTH-1:0] word_nxt;

  always_comb begin
    word_nxt = word_r;
    if (strobe) begin
      word_nxt = wordIn;
    end
  end

  // Held unchanged between strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= WIDTH'(CAPTURE_RESET);
    end else begin
      word_r <= word_nxt;
    end
  end

  assign wordOut = word_r;

endmodule

`default_nettype wire

// ---- hw/telemetry_word_capture_monitor.sv ----
/*
  Telemetry word capture monitor: shifts the decoder's serial stream in on
  the bit clock, counts word pulses down from a BCD preset loaded after each
  frame sync, and captures the selected 16-bit word on counter underflow.
  Assumes all decoder pins are asynchronous to clk and much slower than it.
*/
//
// Contract
// - Shift serial data through sixteen stages, one per bit clock.
// - Shift on the bit clock edge itself, not inverted.
// - Frame sync falling edge starts a 600 us active-low preset pulse.
// - Preset pulse falling edge loads seven-bit BCD word select into counter.
// - Word pulses are NAND-gated with preset; no counting during preset.
// - Each gated word pulse rising edge decrements the BCD count by one.
// - Word pulse after count zero gives active-low underflow, the capture strobe.
// - Capture strobe rising edge copies all sixteen shift stages to holding register.
`timescale 1ns/1ps
`default_nettype none

module telemetry_word_capture_monitor
  import word_capture_pkg::*;
#(
  parameter int WIDTH = WORD_BITS,
  parameter int PRESET_LEN = PRESET_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoder pins
  input wire decoder_pins_t pins,
  // Word select, two BCD digits
  input wire logic [SELECT_BITS-1:0] wordSelect,
  // Captured word and strobes
  output logic [WIDTH-1:0] capturedWord,
  output logic presetActiveN,
  output logic countdownUnderflowN,
  output logic captureStrobe
);

  // Shifter needs two stages, one-shot a real count, select two BCD digits
  if (WIDTH < 2 || PRESET_LEN < 2 || SELECT_BITS != 7) begin : g_badParams
    $error("telemetry_word_capture_monitor: bad parameters");
  end

  localparam int PW = $clog2(PRESET_LEN + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  decoder_pins_t sync1_r, sync2_r, prev_r;
  logic [SELECT_BITS-1:0] selSync1_r, selSync2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
      selSync1_r <= '0;
      selSync2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      selSync1_r <= wordSelect;
      selSync2_r <= selSync1_r;
    end
  end

  // ----------------------------------------------------------------
  // Edge decoders
  // ----------------------------------------------------------------
  function automatic logic riseOf(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic fallOf(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction

  logic bitRise, syncFall;
  assign bitRise = riseOf(sync2_r.bitClock, prev_r.bitClock);
  assign syncFall = fallOf(sync2_r.frameSync, prev_r.frameSync);

  // BCD decrement with borrow
  function automatic bcd_count_t bcdDec(input bcd_count_t c);
    bcd_count_t r;
    r = c;
    if (c.units != 4'h0) begin
      r.units = c.units - 4'h1;
    end else begin
      r.units = 4'h9;
      r.tens = (c.tens == 4'h0) ? 4'h9 : c.tens - 4'h1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] shift_r, shift_nxt;

  always_comb begin
    shift_nxt = shift_r;
    if (bitRise) begin
      shift_nxt = {shift_r[WIDTH-2:0], sync2_r.serialData};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Preset one-shot
  // ----------------------------------------------------------------
  logic [PW-1:0] presetCnt_r, presetCnt_nxt;
  logic presetN_r, presetN_nxt;

  always_comb begin
    presetCnt_nxt = presetCnt_r;
    presetN_nxt = presetN_r;
    if (syncFall) begin
      presetCnt_nxt = PW'(PRESET_LEN - 1);
      presetN_nxt = 1'b0;
    end else if (!presetN_r) begin
      if (presetCnt_r == '0) begin
        presetN_nxt = 1'b1;
      end else begin
        presetCnt_nxt = presetCnt_r - PW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      presetCnt_r <= '0;
      presetN_r <= 1'b1;
    end else begin
      presetCnt_r <= presetCnt_nxt;
      presetN_r <= presetN_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Word counter and underflow
  // ----------------------------------------------------------------
  logic gatedWord, gatedPrev_r, gatedRise, gatedFall, presetFall;
  bcd_count_t count_r, count_nxt;
  logic underN_r, underN_nxt;
  logic strobe_r, strobe_nxt;

  // Inverted sense of the NAND output: high only outside preset
  assign gatedWord = ~(~(sync2_r.wordPulse & presetN_r));
  assign gatedRise = riseOf(gatedWord, gatedPrev_r);
  assign gatedFall = fallOf(gatedWord, gatedPrev_r);
  assign presetFall = fallOf(presetN_nxt, presetN_r);

  always_comb begin
    count_nxt = count_r;
    underN_nxt = underN_r;
    strobe_nxt = 1'b0;
    if (presetFall) begin
      count_nxt.tens = {1'b0, selSync2_r[6:4]};
      count_nxt.units = selSync2_r[3:0];
      underN_nxt = 1'b1;
    end else if (gatedRise) begin
      count_nxt = bcdDec(count_r);
      if (count_r == '0) begin
        underN_nxt = 1'b0;
      end
    end else if (gatedFall && !underN_r) begin
      underN_nxt = 1'b1;
      strobe_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gatedPrev_r <= 1'b0;
      count_r <= '{tens: DIGIT_RESET, units: DIGIT_RESET};
      underN_r <= 1'b1;
      strobe_r <= 1'b0;
    end else begin
      gatedPrev_r <= gatedWord;
      count_r <= count_nxt;
      underN_r <= underN_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Holding register
  // ----------------------------------------------------------------
  capture_holding_reg #(
    .WIDTH(WIDTH)
  ) holdReg (
    .clk(clk),
    .rst(rst),
    .strobe(strobe_nxt),
    .wordIn(shift_r),
    .wordOut(capturedWord)
  );

  assign presetActiveN = presetN_r;
  assign countdownUnderflowN = underN_r;
  assign captureStrobe = strobe_r;

endmodule

`default_nettype wire

// ---- verif/frame_source.sv ----
/*
  Behavioural telemetry frame decoder: drives bit clock, data, word pulse, frame sync.
  Assumes the bench calls send_frame; 320 ns bit period, word i carries 8'hc3 then i.
*/
`timescale 1ns/1ps
`default_nettype none

module frame_source
  import word_capture_pkg::*;
(
  // Decoder pins
  output var decoder_pins_t pins
);
  initial pins = '0;

  task automatic send_frame(input int words);
    logic [15:0] w;
    #7;
    for (int i = 0; i < words; i++) begin
      w = {8'hc3, 8'(i)};
      for (int b = 0; b < WORD_BITS; b++) begin
        pins.bitClock = 1'b0;
        pins.serialData = w[15-b];
        pins.wordPulse = (b == 15);
        pins.frameSync = (i == 0 && b == 0);
        #160;
        pins.frameSync = 1'b0;
        pins.bitClock = 1'b1;
        #160;
      end
    end
    // Clock stands low, released data inverted
    pins.bitClock = 1'b0;
    pins.wordPulse = 1'b0;
    pins.serialData = ~pins.serialData;
  endtask

  // Lone frame sync, bit clock standing low
  task automatic lone_sync;
    #7;
    pins.frameSync = 1'b1;
    #160;
    pins.frameSync = 1'b0;
  endtask

  // Lone word pulse after a gap, bit clock standing low
  task automatic lone_word(input int gapNs);
    #(gapNs);
    pins.wordPulse = 1'b1;
    #160;
    pins.wordPulse = 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- verif/word_capture_checker.sv ----
/*
  Concurrent checks on the capture monitor's ports.
  Assumes binding into telemetry_word_capture_monitor.
*/
`timescale 1ns/1ps
`default_nettype none

module word_capture_checker
  import word_capture_pkg::*;
#(
  parameter int WIDTH = WORD_BITS,
  parameter int PRESET_LEN = PRESET_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire decoder_pins_t pins,
  input wire logic [SELECT_BITS-1:0] wordSelect,
  // Outputs
  input wire logic [WIDTH-1:0] capturedWord,
  input wire logic presetActiveN,
  input wire logic countdownUnderflowN,
  input wire logic captureStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int lowCnt_r, lowCnt_nxt;
  always_comb lowCnt_nxt = presetActiveN ? 0 : lowCnt_r + 1;
  always_ff @(posedge clk) lowCnt_r <= rst ? 0 : lowCnt_nxt;

  sequence s_strobe;
    captureStrobe ##1 !captureStrobe;
  endsequence
  sequence s_uflowLow;
    !countdownUnderflowN [*4];
  endsequence

  AST_PRESET_START: assert property ($fell(pins.frameSync) |-> ##[1:4] !presetActiveN)
    else $error("preset did not start");
  AST_PRESET_CAUSE: assert property ($fell(presetActiveN) |-> !pins.frameSync)
    else $error("preset without frame sync end");
  AST_PRESET_LEN: assert property ($rose(presetActiveN) |-> lowCnt_r == PRESET_LEN)
    else $error("preset length wrong");
  AST_NO_COUNT: assert property (!presetActiveN |-> countdownUnderflowN && !captureStrobe)
    else $error("activity during preset");
  AST_UFLOW_CAUSE: assert property ($fell(countdownUnderflowN) |-> pins.wordPulse ##0 s_uflowLow)
    else $error("underflow without word pulse");
  AST_UFLOW_END: assert property ($rose(countdownUnderflowN) |-> !pins.wordPulse ##0 s_strobe)
    else $error("capture strobe missing");
  AST_STROBE_CAUSE: assert property (captureStrobe |-> countdownUnderflowN && !$past(countdownUnderflowN))
    else $error("strobe without underflow end");
  AST_HOLD: assert property ($changed(capturedWord) && !$past(rst) |-> captureStrobe)
    else $error("held word changed");
endmodule

bind telemetry_word_capture_monitor word_capture_checker #(.WIDTH(WIDTH), .PRESET_LEN(PRESET_LEN)) u_chk (
  .clk(clk), .rst(rst), .pins(pins), .wordSelect(wordSelect), .capturedWord(capturedWord),
  .presetActiveN(presetActiveN), .countdownUnderflowN(countdownUnderflowN), .captureStrobe(captureStrobe));

`default_nettype wire

// ---- verif/testbench.sv ----
/*
  Self-checking bench: frames with several word selections, a short frame, reset.
  Assumes frame_source as the decoder and a shortened preset.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
  import word_capture_pkg::*;
  typedef struct { logic [6:0] sel; int words; logic [15:0] exp; } row_t;
  row_t rows [5] = '{'{7'h00, 2, 16'hc300}, '{7'h01, 3, 16'hc301}, '{7'h09, 11, 16'hc309},
    '{7'h10, 12, 16'hc30a}, '{7'h64, 66, 16'hc340}};
  logic clk, rst;
  logic [SELECT_BITS-1:0] wordSelect;
  decoder_pins_t pins;
  logic [WORD_BITS-1:0] capturedWord;
  logic presetActiveN, countdownUnderflowN, captureStrobe;
  int fails, num_checks, strobes, base;

  frame_source u_src (.pins(pins));
  telemetry_word_capture_monitor #(.PRESET_LEN(20)) u_dut (.clk(clk), .rst(rst), .pins(pins),
    .wordSelect(wordSelect), .capturedWord(capturedWord), .presetActiveN(presetActiveN),
    .countdownUnderflowN(countdownUnderflowN), .captureStrobe(captureStrobe));

  task automatic close_out;
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) if (captureStrobe === 1'b1) strobes++;

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out;
  end

  initial begin
    rst = 1'b1;
    wordSelect = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHECK({capturedWord, presetActiveN, countdownUnderflowN, captureStrobe}, 19'h00006)
    foreach (rows[i]) begin
      wordSelect <= rows[i].sel;
      @(posedge clk);
      base = strobes;
      u_src.send_frame(rows[i].words);
      repeat (8) @(posedge clk);
      `CHECK(capturedWord, rows[i].exp)
      `CHECK(strobes - base, 1)
    end
    // Frame too short for the selected word
    wordSelect <= 7'h05;
    @(posedge clk);
    base = strobes;
    u_src.send_frame(3);
    repeat (8) @(posedge clk);
    `CHECK(strobes - base, 0)
    `CHECK(capturedWord, 16'hc340)
    // Word pulse inside the preset is refused, the next one captures
    wordSelect <= 7'h00;
    @(posedge clk);
    base = strobes;
    u_src.lone_sync();
    u_src.lone_word(200);
    repeat (30) @(posedge clk);
    `CHECK(strobes - base, 0)
    u_src.lone_word(7);
    repeat (8) @(posedge clk);
    `CHECK(strobes - base, 1)
    `CHECK(capturedWord, 16'hc302)
    // Mid-run reset clears the held word
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHECK({capturedWord, presetActiveN, countdownUnderflowN, captureStrobe}, 19'h00006)
    close_out;
  end
endmodule

`default_nettype wire
